// >>> verilog/pms_pkg.sv
`default_nettype none

package pms_pkg;

    // power states, highest first
    typedef enum logic [1:0] {
        PMS_ACTIVE,
        PMS_IDLE,
        PMS_SLEEP,
        PMS_DEEP
    } pms_state_t;

    localparam int          PMS_TIMER_W      = 24;
    localparam logic [23:0] PMS_PERIOD_RST   = 24'h00_4E20; // 1 ms at 20 MHz
    localparam logic [23:0] PMS_WAKE_RST     = 24'h00_4E20;
    localparam int          PMS_SYNC_STAGES  = 3;

    // power-down controls toward the transceiver, high = powered down
    typedef struct packed {
        logic tx_pd;
        logic rx_pd;
        logic pll_pd;
        logic pa_pd;
    } pms_rf_pd_t;

    // packet-handler requests for the radio
    typedef struct packed {
        logic tx_need;
        logic rx_need;
    } pms_pkt_t;

    // supply enables
    typedef struct packed {
        logic core_supply_output;
        logic amplifier_supply;
        logic regulator_en;
        logic io_supply_domain;
    } pms_supply_t;

endpackage : pms_pkg

`default_nettype wire

// >>> verilog/pms_sync.sv
`timescale 1ns/10ps
`default_nettype none

// three-stage input synchroniser; a change counts once stages two and three agree
module pms_sync
    import pms_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic [PMS_SYNC_STAGES-1:0] sh_reg;

    // stage one is read only by stage two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= {sh_reg[PMS_SYNC_STAGES-2:0], din};
        end
    end

    // hold the output until the last two stages agree, filtering a one-cycle glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (sh_reg[1] == sh_reg[2]) begin
            dout <= sh_reg[2];
        end
    end
endmodule : pms_sync

`default_nettype wire

// >>> verilog/pms_sequencer.sv
// Notes on behaviour
// R1: four states: active, idle, sleep, deep sleep
// R2: inactivity expiry steps one state lower
// R3: activity returns straight to active
// R4: deep sleep cuts core and amplifier supplies
// R5: io domain stays up, wakes chip
// R6: separate tx, rx, pll, pa power-downs
// R7: radio on only while packet needs it
// R8: low-power connection runs slow, timed wake
// R9: regulator off under firmware in deep sleep
// R10: triggers from software and user pin events
// R11: timer restarts on activity and state change
`timescale 1ns/10ps
`default_nettype none

module pms_sequencer
    import pms_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   user_event,
    input  wire logic [PMS_TIMER_W-1:0] idle_period,
    input  wire logic [PMS_TIMER_W-1:0] wake_interval,
    input  wire logic                   sw_force_deep,
    input  wire logic                   sw_wake,
    input  wire logic                   fw_reg_off_en,
    input  wire logic                   lp_conn_req,
    input  wire pms_pkt_t               pkt,
    output var  pms_state_t             state,
    output var  pms_rf_pd_t             rf_pd,
    output var  pms_supply_t            supply,
    output var  logic                   lpo_select,
    output var  logic                   timed_wake
);
    pms_state_t             state_reg;
    pms_state_t             state_next;
    logic [PMS_TIMER_W-1:0] idle_cnt_reg;
    logic [PMS_TIMER_W-1:0] wake_cnt_reg;
    logic                   user_sync;
    logic                   user_prev_reg;
    logic                   activity;
    logic                   expiry;
    logic                   wake_exp;

    // core power is cut only in deep sleep; the radio is cut there whatever the packet needs
    function automatic logic pms_powered(input pms_state_t s);
        return s != PMS_DEEP;
    endfunction : pms_powered

    // pin input from the always-on io domain
    pms_sync u_user_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (user_event),
        .dout (user_sync)
    );

    // rising edge of the filtered user input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            user_prev_reg <= 1'b0;
        end else begin
            user_prev_reg <= user_sync;
        end
    end

    // the io domain detects events even in deep sleep; software wake counts too
    assign activity = (user_sync & ~user_prev_reg) | sw_wake; // R5 R10
    // limitation: a zero period lets the counter run on, so a new period may expire at once
    assign expiry   = (idle_cnt_reg >= idle_period) && (idle_period != '0);

    // next state: activity wins over expiry so an event is never lost
    always_comb begin
        state_next = state_reg;
        if (activity) begin
            state_next = PMS_ACTIVE; // R3
        end else if (sw_force_deep) begin
            state_next = PMS_DEEP; // R10
        end else if (expiry) begin
            case (state_reg) // R2
                PMS_ACTIVE: state_next = PMS_IDLE;
                PMS_IDLE:   state_next = PMS_SLEEP;
                PMS_SLEEP:  state_next = PMS_DEEP;
                PMS_DEEP:   state_next = PMS_DEEP;
                default:    state_next = PMS_ACTIVE;
            endcase
        end
    end

    // power state register; only the four encodings exist
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= PMS_ACTIVE; // R1
        end else begin
            state_reg <= state_next;
        end
    end

    // inactivity timer, cleared on activity or any state change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_cnt_reg <= '0;
        end else if (activity || state_next != state_reg) begin
            idle_cnt_reg <= '0; // R11
        end else if (!expiry) begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
    end

    // low-power connection interval timer; limitation: counts in clk cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_cnt_reg <= '0;
        end else if (!lp_conn_req || wake_exp) begin
            wake_cnt_reg <= '0;
        end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1; // R8
        end
    end

    assign wake_exp = lp_conn_req && (wake_cnt_reg + 1'b1 >= wake_interval);

    // lpo select and timed wake pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lpo_select <= 1'b0;
            timed_wake <= 1'b0;
        end else begin
            lpo_select <= lp_conn_req && !wake_exp; // R8
            timed_wake <= wake_exp; // R8
        end
    end

    // registered state output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PMS_ACTIVE;
        end else begin
            state <= state_next;
        end
    end

    // supplies follow the next state so they change with the state output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply <= '{1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            supply.core_supply_output <= pms_powered(state_next); // R4
            supply.amplifier_supply   <= pms_powered(state_next); // R4
            supply.regulator_en       <= pms_powered(state_next) || !fw_reg_off_en; // R9
            supply.io_supply_domain   <= 1'b1; // R5
        end
    end

    // radio paths powered only when the packet needs them and the core is up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rf_pd <= '{1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            rf_pd.tx_pd  <= !(pkt.tx_need && pms_powered(state_next)); // R6 R7
            rf_pd.rx_pd  <= !(pkt.rx_need && pms_powered(state_next)); // R6 R7
            rf_pd.pll_pd <= !((pkt.tx_need | pkt.rx_need) && pms_powered(state_next)); // R6
            rf_pd.pa_pd  <= !(pkt.tx_need && pms_powered(state_next)); // R6 R7
        end
    end

    AST_WAKE_ACTIVE: assert property (@(posedge clk) disable iff (rst) // R3
        activity |=> state == PMS_ACTIVE)
        else $error("activity did not return to active");

    AST_STEP_ONE: assert property (@(posedge clk) disable iff (rst) // R2
        (state_reg != state_next && !activity && !sw_force_deep)
        |-> state_next == pms_state_t'(state_reg + 2'd1))
        else $error("step skipped a state");

    AST_DEEP_SUPPLY: assert property (@(posedge clk) disable iff (rst) // R4
        state == PMS_DEEP |-> !supply.core_supply_output && !supply.amplifier_supply)
        else $error("supplies on in deep sleep");

    AST_IO_UP: assert property (@(posedge clk) disable iff (rst) // R5
        supply.io_supply_domain)
        else $error("io domain dropped");

    AST_REG_OFF: assert property (@(posedge clk) disable iff (rst) // R9
        (state_next == PMS_DEEP && fw_reg_off_en) |=> !supply.regulator_en)
        else $error("regulator not disabled");

    AST_RADIO_IDLE: assert property (@(posedge clk) disable iff (rst) // R7
        !pkt.tx_need && !pkt.rx_need |=> rf_pd.tx_pd && rf_pd.rx_pd && rf_pd.pll_pd)
        else $error("radio powered without packet");

    AST_TX_ON: assert property (@(posedge clk) disable iff (rst) // R6
        (pkt.tx_need && state_next != PMS_DEEP) |=> !rf_pd.tx_pd && !rf_pd.pa_pd)
        else $error("tx path not powered");

    AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (rst) // R11
        (state_reg != state_next) |=> idle_cnt_reg == '0)
        else $error("timer not restarted");

    AST_FORCE_DEEP: assert property (@(posedge clk) disable iff (rst) // R10
        (sw_force_deep && !activity) |=> state == PMS_DEEP)
        else $error("software deep sleep ignored");

    // the radio must stay dark whatever the packet handler asks while the core is off
    AST_RADIO_DEEP: assert property (@(posedge clk) disable iff (rst) // R7
        state == PMS_DEEP |-> rf_pd.tx_pd && rf_pd.rx_pd && rf_pd.pll_pd && rf_pd.pa_pd)
        else $error("radio powered in deep sleep");

    AST_RX_ON: assert property (@(posedge clk) disable iff (rst) // R6
        (pkt.rx_need && pms_powered(state_next)) |=> !rf_pd.rx_pd && !rf_pd.pll_pd)
        else $error("rx path not powered");

    AST_LPO_PULSE: assert property (@(posedge clk) disable iff (rst) // R8
        timed_wake |-> !lpo_select)
        else $error("slow clock kept at timed wake");

    AST_NO_STEP: assert property (@(posedge clk) disable iff (rst) // R2
        (idle_period == '0 && !activity && !sw_force_deep) |=> $stable(state))
        else $error("stepped with stepping disabled");
endmodule : pms_sequencer

`default_nettype wire

// >>> verification/pms_user_model.sv
`timescale 1ns/10ps
`default_nettype none

// user activity source: each poke gives a key press held for eight clocks,
// long enough to pass the three-flop input filter
module pms_user_model (
    input  wire logic clk,
    input  wire logic poke,
    output var  logic user_event
);
    int hold_cnt = 0;

    // press starts on the clock after the poke, released by count
    always_ff @(posedge clk) begin
        if (poke) begin
            hold_cnt <= 8;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end

    assign user_event = (hold_cnt > 0);
endmodule : pms_user_model
`default_nettype wire

// >>> verification/power_mode_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module power_mode_sequencer_tb
    import pms_pkg::*;
();

    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   sw_force_deep = 1'b0;
    logic                   sw_wake = 1'b0;
    logic                   fw_reg_off_en = 1'b1;
    logic                   lp_conn_req = 1'b0;
    logic                   poke = 1'b0;
    logic                   user_event;
    logic [PMS_TIMER_W-1:0] idle_period = 24'h00_0000;
    logic [PMS_TIMER_W-1:0] wake_interval = 24'h00_000A;
    pms_pkt_t               pkt = 2'h0;
    pms_state_t             state;
    pms_rf_pd_t             rf_pd;
    pms_supply_t            supply;
    logic                   lpo_select;
    logic                   timed_wake;
    int                     failures = 0;
    int                     n_compared = 0;
    int                     n;
    // rows: {tx_need, rx_need, expected tx_pd, rx_pd, pll_pd, pa_pd}
    logic [5:0]             rows [4] = '{6'h0F, 6'h19, 6'h24, 6'h30};

    pms_sequencer pms_sequencer_inst (.clk(clk), .rst(rst), .user_event(user_event),
        .idle_period(idle_period), .wake_interval(wake_interval),
        .sw_force_deep(sw_force_deep), .sw_wake(sw_wake), .fw_reg_off_en(fw_reg_off_en),
        .lp_conn_req(lp_conn_req), .pkt(pkt), .state(state), .rf_pd(rf_pd),
        .supply(supply), .lpo_select(lpo_select), .timed_wake(timed_wake));
    pms_user_model pms_user_model_inst (.clk(clk), .poke(poke), .user_event(user_event));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // inputs move a fixed 5 ns after the edge
    task automatic tick;
        @(posedge clk);
        #5;
    endtask : tick

    // bounded wait for the next state change; n gives the cycles taken
    task automatic wait_change(input int lim);
        pms_state_t prev;
        prev = state;
        n = 0;
        while (state === prev && n < lim) begin
            tick();
            n++;
        end
    endtask : wait_change

    task automatic wait_pulse(input int lim);
        n = 0;
        do begin
            tick();
            n++;
        end while (timed_wake !== 1'b1 && n < lim);
    endtask : wait_pulse

    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // the whole run needs well under a thousand cycles
    initial begin
        #(50 * 3000);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (20) tick();
        check("rst_state", 8'(state), 8'h00);
        check("rst_supply", 8'(supply), 8'h0F);
        check("rst_rf_pd", 8'(rf_pd), 8'h0F);
        check("rst_lp", {6'h0, lpo_select, timed_wake}, 8'h00);
        rst = 1'b0;
        // packet needs decide the radio power-downs; no stepping meanwhile
        for (int r = 0; r < 4; r++) begin
            pkt = rows[r][5:4];
            repeat (3) tick();
            check("rf_pd", 8'(rf_pd), 8'(rows[r][3:0]));
        end
        pkt = 2'h0;
        // inactivity walk, first step at once (counter ran on), then one state per full period, stopping at deep sleep
        idle_period = 24'h00_0008;
        for (int i = 1; i < 4; i++) begin
            wait_change(40);
            check("step_state", 8'(state), 8'(i));
            if (i > 1) begin
                check("step_gap", 8'(n >= 8 && n <= 10), 8'h01);
            end
        end
        repeat (30) tick();
        check("deep_hold", 8'(state), 8'h03);
        check("deep_supply", 8'(supply), 8'h01);
        idle_period = 24'h00_0000;
        poke = 1'b1;
        tick();
        poke = 1'b0;
        wait_change(20);
        check("wake_state", 8'(state), 8'h00);
        check("wake_supply", 8'(supply), 8'h0F);
        // software forces deep sleep with the regulator kept, then firmware drops it
        fw_reg_off_en = 1'b0;
        sw_force_deep = 1'b1;
        wait_change(10);
        check("sw_deep", 8'(state), 8'h03);
        check("reg_kept", 8'(supply), 8'h03);
        fw_reg_off_en = 1'b1;
        pkt = 2'h3;
        tick();
        check("reg_fw_off", 8'(supply), 8'h01);
        check("deep_rf_pd", 8'(rf_pd), 8'h0F);
        pkt = 2'h0;
        sw_force_deep = 1'b0;
        sw_wake = 1'b1;
        wait_change(10);
        check("sw_wake", 8'(state), 8'h00);
        sw_wake = 1'b0;
        // low-power connection: slow clock between timed wakes
        lp_conn_req = 1'b1;
        wait_pulse(40);
        wait_pulse(40);
        check("wake_gap", 8'(n), 8'h0A);
        check("lpo_at_pulse", 8'(lpo_select), 8'h00);
        tick();
        check("lpo_wait", {6'h0, lpo_select, timed_wake}, 8'h02);
        // mid-run reset out of deep sleep while the slow clock is in use
        sw_force_deep = 1'b1;
        tick();
        check("pre_rst", 8'(state), 8'h03);
        rst = 1'b1;
        sw_force_deep = 1'b0;
        tick();
        check("mid_rst_state", 8'(state), 8'h00);
        check("mid_rst_supply", 8'(supply), 8'h0F);
        check("mid_rst_rf_pd", 8'(rf_pd), 8'h0F);
        check("mid_rst_lp", {6'h0, lpo_select, timed_wake}, 8'h00);
        tick();
        rst = 1'b0;
        // the interval timer restarts from zero after reset
        wait_pulse(40);
        check("wake_after_rst", 8'(n), 8'h0A);
        report_and_stop();
    end
endmodule : power_mode_sequencer_tb
`default_nettype wire
